/* rtl/arec_params.svh */
/*
 * Register offsets, field positions, reset values and fixed filter
 * constants of the record-path enhancement chain.
 * Assumes a 16-bit register word and a single 100 MHz clock.
 */
`ifndef AREC_PARAMS_SVH
`define AREC_PARAMS_SVH

// register offsets
`define AREC_OFS_CONV_CTRL_A 16'h0005
`define AREC_OFS_CONV_CTRL_B 16'h0006
`define AREC_OFS_BAND_CTRL 16'h0108
`define AREC_OFS_BAND_COEFF 16'h0109
`define AREC_OFS_MONO_CTRL 16'h010A
`define AREC_OFS_WIDEN_CTRL 16'h010C
`define AREC_OFS_WIDEN_LEFT 16'h010D
`define AREC_OFS_CROSS_COEFF 16'h010E
`define AREC_OFS_WIDEN_RIGHT 16'h010F

// field positions
`define AREC_BIT_DC_DISABLE 0
`define AREC_BIT_DC_ORDER 10
`define AREC_LSB_DC_CORNER 7
`define AREC_LSB_RATE_BAND 12
`define AREC_BIT_BAND_ENABLE 0
`define AREC_BIT_BAND_TYPE 1
`define AREC_BIT_MONO_MIX 0
`define AREC_BIT_WIDEN_ENABLE 0
`define AREC_BIT_CROSS_ENABLE 1
`define AREC_BIT_CROSS_TYPE 2
`define AREC_BIT_POL_RIGHT 4
`define AREC_BIT_POL_LEFT 5
`define AREC_LSB_FWD_GAIN 11
`define AREC_LSB_CROSS_GAIN 6
`define AREC_LSB_CROSS_DELAY 2

// reset values
`define AREC_RST_RATE_BAND 2'h2
`define AREC_RST_DC_CORNER 3'h0
`define AREC_RST_GAIN 5'h00
`define AREC_RST_DELAY 4'h0
`define AREC_RST_COEFF 16'h0000

// filter constants
`define AREC_MAX_DELAY 4'h8
`define AREC_HP_SHIFT 12
`define AREC_HIFI_COEF 12'h002
`define AREC_LP_SHIFT 16
`define AREC_GAIN_SHIFT 15

`endif

/* rtl/arec_pkg.sv */
/*
 * Types shared by the record-path enhancement chain.
 * Assumes the constants of arec_params.svh are included alongside.
 */
package arec_pkg;
   typedef enum logic [1:0] {
      AREC_BAND_8K = 2'h0,
      AREC_BAND_16K = 2'h1,
      AREC_BAND_32K = 2'h2,
      AREC_BAND_96K = 2'h3
   } arec_rate_band_t;

   typedef enum logic {
      AREC_LOWPASS = 1'b0,
      AREC_HIGHPASS = 1'b1
   } arec_filter_type_t;
endpackage : arec_pkg

/* rtl/arec_fifo.sv */
/*
 * Flip-flop FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-high reset.
 */
module arec_fifo
   import arec_pkg::*;
#(
   parameter int WIDTH = 48,
   parameter int DEPTH = 8
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge CLK) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   a_fifo_no_overflow: assert property (@(posedge CLK) disable iff (RST)
      (count == (AW+1)'(DEPTH)) |=> (count <= (AW+1)'(DEPTH)))
      else $error("fifo count passed its depth");
endmodule : arec_fifo

/* rtl/arec_chain.sv */
/*
 * Record-path enhancement chain: dc-blocking high-pass, band filter,
 * stereo widening, behind a plain register port and an input FIFO.
 * Assumes samples and strobes synchronous to CLK; the upstream
 * decimator honours SAMPLE_READY and the downstream path OUT_VALID.
 */
// Strobed register access was decided locally.
`include "arec_params.svh"
module arec_chain
   import arec_pkg::*;
#(
   parameter int DATA_W = 24,
   parameter int FIFO_DEPTH = 8
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic [15:0] ADDRESS,
   input wire logic [15:0] WRITE_DATA,
   input wire logic WRITE_STROBE,
   input wire logic READ_STROBE,
   output logic [15:0] READ_DATA,
   input wire logic [1:0] RATE_BAND,
   input wire logic SAMPLE_VALID,
   output logic SAMPLE_READY,
   input wire logic signed [DATA_W-1:0] SAMPLE_LEFT,
   input wire logic signed [DATA_W-1:0] SAMPLE_RIGHT,
   output logic OUT_VALID,
   input wire logic OUT_READY,
   output logic signed [DATA_W-1:0] OUT_LEFT,
   output logic signed [DATA_W-1:0] OUT_RIGHT
);
   localparam int IW = DATA_W + 8;
   localparam int HP_SH = `AREC_HP_SHIFT;
   localparam int LP_SH = `AREC_LP_SHIFT;
   localparam int G_SH = `AREC_GAIN_SHIFT;
   localparam logic [16:0] GAIN_TABLE [32] = '{
      17'h00000, 17'h0230D, 17'h02499, 17'h02637, 17'h027E6, 17'h029A9, 17'h02B7F, 17'h02D6B,
      17'h02F6C, 17'h03183, 17'h033B2, 17'h035FA, 17'h0385C, 17'h03AD8, 17'h03D71, 17'h04027,
      17'h042FC, 17'h045F0, 17'h04906, 17'h04C3F, 17'h04F9C, 17'h0531F, 17'h056CA, 17'h05A9E,
      17'h05E9D, 17'h062CA, 17'h06726, 17'h06BB3, 17'h07074, 17'h07569, 17'h07A98, 17'h08000};
   localparam logic [11:0] CORNER_TABLE [8] = '{
      12'h040, 12'h051, 12'h068, 12'h081, 12'h0A1, 12'h0CF, 12'h101, 12'h142};

   // register fields
   logic dc_block_disable;
   logic dc_block_order_select;
   logic [2:0] dc_block_corner_code;
   arec_rate_band_t dc_block_rate_band;
   logic band_filter_enable;
   logic band_filter_type;
   logic [15:0] band_filter_coefficient;
   logic record_mono_mix;
   logic widen_enable;
   logic widen_cross_filter_enable;
   logic widen_cross_filter_type;
   logic widen_cross_polarity_left;
   logic widen_cross_polarity_right;
   logic [15:0] widen_cross_coefficient;
   logic [4:0] fwd_gain [2];
   logic [4:0] cross_gain [2];
   logic [3:0] cross_delay [2];

   // datapath state, index 0 left, 1 right
   logic signed [IW-1:0] dc_x1 [2];
   logic signed [IW-1:0] dc_y1 [2];
   logic signed [IW-1:0] dc_x2 [2];
   logic signed [IW-1:0] dc_y2 [2];
   logic signed [IW-1:0] bf_y [2];
   logic signed [IW-1:0] cf_y [2];
   logic signed [IW-1:0] hist [2][8];

   logic head_valid;
   logic [2*DATA_W-1:0] head_data;
   logic take;
   logic signed [IW-1:0] x [2];
   logic signed [IW-1:0] s1 [2];
   logic signed [IW-1:0] s2 [2];
   logic signed [IW-1:0] dc_out [2];
   logic signed [IW-1:0] bf_lp [2];
   logic signed [IW-1:0] bf_out [2];
   logic signed [IW-1:0] cf_lp [2];
   logic signed [IW-1:0] cf_out [2];
   logic signed [IW-1:0] cross_sig [2];
   logic signed [IW-1:0] next_out [2];
   logic [11:0] dc_coef;
   logic [15:0] read_value;

   function automatic logic hit(input logic [15:0] ofs);
      hit = (ADDRESS == ofs);
   endfunction : hit

   function automatic logic signed [IW-1:0] hp1(input logic signed [IW-1:0] xin,
         input logic signed [IW-1:0] xp, input logic signed [IW-1:0] yp, input logic [11:0] c);
      logic signed [IW+13:0] prod;
      prod = yp * $signed({1'b0, c});
      hp1 = IW'(xin - xp + yp - IW'(prod >>> HP_SH));
   endfunction : hp1

   function automatic logic signed [IW-1:0] lp1(input logic signed [IW-1:0] xin,
         input logic signed [IW-1:0] yp, input logic [15:0] k);
      logic signed [IW+17:0] prod;
      prod = (xin - yp) * $signed({1'b0, k});
      lp1 = IW'(yp + IW'(prod >>> LP_SH));
   endfunction : lp1

   function automatic logic signed [IW-1:0] scale(input logic signed [IW-1:0] v,
         input logic [4:0] code);
      logic signed [IW+17:0] prod;
      prod = v * $signed({1'b0, GAIN_TABLE[code]});
      scale = IW'(prod >>> G_SH);
   endfunction : scale

   function automatic logic signed [DATA_W-1:0] sat(input logic signed [IW-1:0] v);
      logic signed [IW-1:0] hi;
      logic signed [IW-1:0] lo;
      hi = IW'({1'b0, {(DATA_W-1){1'b1}}});
      lo = -hi - IW'(1);
      if (v > hi) begin
         sat = hi[DATA_W-1:0];
      end else if (v < lo) begin
         sat = lo[DATA_W-1:0];
      end else begin
         sat = v[DATA_W-1:0];
      end
   endfunction : sat

   arec_fifo #(
      .WIDTH(2 * DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .CLK(CLK),
      .RST(RST),
      .in_valid(SAMPLE_VALID),
      .in_ready(SAMPLE_READY),
      .in_data({SAMPLE_LEFT, SAMPLE_RIGHT}),
      .out_valid(head_valid),
      .out_ready(take),
      .out_data(head_data)
   );

   assign take = head_valid && (!OUT_VALID || OUT_READY);

   // converter controls
   always_ff @(posedge CLK) begin
      if (RST) begin
         dc_block_disable <= 1'b0;
         dc_block_order_select <= 1'b0;
         dc_block_corner_code <= `AREC_RST_DC_CORNER;
      end else if (WRITE_STROBE) begin
         if (hit(`AREC_OFS_CONV_CTRL_A)) begin
            dc_block_disable <= WRITE_DATA[`AREC_BIT_DC_DISABLE];
         end
         if (hit(`AREC_OFS_CONV_CTRL_B)) begin
            dc_block_order_select <= WRITE_DATA[`AREC_BIT_DC_ORDER];
            dc_block_corner_code <= WRITE_DATA[`AREC_LSB_DC_CORNER +: 3];
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         dc_block_rate_band <= arec_rate_band_t'(`AREC_RST_RATE_BAND);
      end else begin
         dc_block_rate_band <= arec_rate_band_t'(RATE_BAND);
      end
   end

   // band filter and mono controls
   always_ff @(posedge CLK) begin
      if (RST) begin
         band_filter_enable <= 1'b0;
         band_filter_type <= 1'b0;
         band_filter_coefficient <= `AREC_RST_COEFF;
         record_mono_mix <= 1'b0;
      end else if (WRITE_STROBE) begin
         if (hit(`AREC_OFS_BAND_CTRL)) begin
            band_filter_enable <= WRITE_DATA[`AREC_BIT_BAND_ENABLE];
            band_filter_type <= WRITE_DATA[`AREC_BIT_BAND_TYPE];
         end
         if (hit(`AREC_OFS_BAND_COEFF)) begin
            band_filter_coefficient <= WRITE_DATA;
         end
         if (hit(`AREC_OFS_MONO_CTRL)) begin
            record_mono_mix <= WRITE_DATA[`AREC_BIT_MONO_MIX];
         end
      end
   end

   // widening controls
   always_ff @(posedge CLK) begin
      if (RST) begin
         widen_enable <= 1'b0;
         widen_cross_filter_enable <= 1'b0;
         widen_cross_filter_type <= 1'b0;
         widen_cross_polarity_left <= 1'b0;
         widen_cross_polarity_right <= 1'b0;
         widen_cross_coefficient <= `AREC_RST_COEFF;
         for (int ch = 0; ch < 2; ch++) begin
            fwd_gain[ch] <= `AREC_RST_GAIN;
            cross_gain[ch] <= `AREC_RST_GAIN;
            cross_delay[ch] <= `AREC_RST_DELAY;
         end
      end else if (WRITE_STROBE) begin
         if (hit(`AREC_OFS_WIDEN_CTRL)) begin
            widen_enable <= WRITE_DATA[`AREC_BIT_WIDEN_ENABLE];
            widen_cross_filter_enable <= WRITE_DATA[`AREC_BIT_CROSS_ENABLE];
            widen_cross_filter_type <= WRITE_DATA[`AREC_BIT_CROSS_TYPE];
            widen_cross_polarity_left <= WRITE_DATA[`AREC_BIT_POL_LEFT];
            widen_cross_polarity_right <= WRITE_DATA[`AREC_BIT_POL_RIGHT];
         end
         if (hit(`AREC_OFS_CROSS_COEFF)) begin
            widen_cross_coefficient <= WRITE_DATA;
         end
         if (hit(`AREC_OFS_WIDEN_LEFT)) begin
            fwd_gain[0] <= WRITE_DATA[`AREC_LSB_FWD_GAIN +: 5];
            cross_gain[0] <= WRITE_DATA[`AREC_LSB_CROSS_GAIN +: 5];
            cross_delay[0] <= WRITE_DATA[`AREC_LSB_CROSS_DELAY +: 4];
         end
         if (hit(`AREC_OFS_WIDEN_RIGHT)) begin
            fwd_gain[1] <= WRITE_DATA[`AREC_LSB_FWD_GAIN +: 5];
            cross_gain[1] <= WRITE_DATA[`AREC_LSB_CROSS_GAIN +: 5];
            cross_delay[1] <= WRITE_DATA[`AREC_LSB_CROSS_DELAY +: 4];
         end
      end
   end

   // register readback mux
   always_comb begin
      read_value = 16'h0000;
      case (ADDRESS)
         `AREC_OFS_CONV_CTRL_A: read_value[`AREC_BIT_DC_DISABLE] = dc_block_disable;
         `AREC_OFS_CONV_CTRL_B: begin
            read_value[`AREC_LSB_RATE_BAND +: 2] = dc_block_rate_band;
            read_value[`AREC_BIT_DC_ORDER] = dc_block_order_select;
            read_value[`AREC_LSB_DC_CORNER +: 3] = dc_block_corner_code;
         end
         `AREC_OFS_BAND_CTRL: begin
            read_value[`AREC_BIT_BAND_ENABLE] = band_filter_enable;
            read_value[`AREC_BIT_BAND_TYPE] = band_filter_type;
         end
         `AREC_OFS_BAND_COEFF: read_value = band_filter_coefficient;
         `AREC_OFS_MONO_CTRL: read_value[`AREC_BIT_MONO_MIX] = record_mono_mix;
         `AREC_OFS_WIDEN_CTRL: begin
            read_value[`AREC_BIT_WIDEN_ENABLE] = widen_enable;
            read_value[`AREC_BIT_CROSS_ENABLE] = widen_cross_filter_enable;
            read_value[`AREC_BIT_CROSS_TYPE] = widen_cross_filter_type;
            read_value[`AREC_BIT_POL_LEFT] = widen_cross_polarity_left;
            read_value[`AREC_BIT_POL_RIGHT] = widen_cross_polarity_right;
         end
         `AREC_OFS_CROSS_COEFF: read_value = widen_cross_coefficient;
         `AREC_OFS_WIDEN_LEFT: read_value = {fwd_gain[0], cross_gain[0], cross_delay[0], 2'h0};
         `AREC_OFS_WIDEN_RIGHT: read_value = {fwd_gain[1], cross_gain[1], cross_delay[1], 2'h0};
         default: read_value = 16'h0000;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         READ_DATA <= 16'h0000;
      end else begin
         READ_DATA <= READ_STROBE ? read_value : 16'h0000;
      end
   end

   assign dc_coef = dc_block_order_select ? CORNER_TABLE[dc_block_corner_code] : `AREC_HIFI_COEF;

   // datapath, all combinational up to the output register
   always_comb begin
      for (int ch = 0; ch < 2; ch++) begin
         x[ch] = IW'($signed(ch == 0 ? head_data[2*DATA_W-1:DATA_W] : head_data[DATA_W-1:0]));
         s1[ch] = hp1(x[ch], dc_x1[ch], dc_y1[ch], dc_coef);
         s2[ch] = hp1(s1[ch], dc_x2[ch], dc_y2[ch], dc_coef);
         dc_out[ch] = dc_block_disable ? x[ch] : (dc_block_order_select ? s2[ch] : s1[ch]);
         bf_lp[ch] = lp1(dc_out[ch], bf_y[ch], band_filter_coefficient);
         bf_out[ch] = dc_out[ch];
         if (band_filter_enable) begin
            bf_out[ch] = band_filter_type ? dc_out[ch] - bf_lp[ch] : bf_lp[ch];
         end
      end
      for (int ch = 0; ch < 2; ch++) begin
         cf_lp[ch] = lp1(bf_out[1-ch], cf_y[ch], widen_cross_coefficient);
         cf_out[ch] = bf_out[1-ch];
         if (widen_cross_filter_enable) begin
            cf_out[ch] = widen_cross_filter_type ? bf_out[1-ch] - cf_lp[ch] : cf_lp[ch];
         end
         if (cross_delay[ch] == 4'h0) begin
            cross_sig[ch] = cf_out[ch];
         end else if (cross_delay[ch] > `AREC_MAX_DELAY) begin
            cross_sig[ch] = hist[ch][7];
         end else begin
            cross_sig[ch] = hist[ch][3'(cross_delay[ch] - 4'h1)];
         end
         if (widen_enable) begin
            if ((ch == 0) ? widen_cross_polarity_left : widen_cross_polarity_right) begin
               next_out[ch] = scale(bf_out[ch], fwd_gain[ch]) - scale(cross_sig[ch], cross_gain[ch]);
            end else begin
               next_out[ch] = scale(bf_out[ch], fwd_gain[ch]) + scale(cross_sig[ch], cross_gain[ch]);
            end
         end else if (record_mono_mix) begin
            next_out[ch] = (bf_out[0] + bf_out[1]) >>> 1;
         end else begin
            next_out[ch] = bf_out[ch];
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         for (int ch = 0; ch < 2; ch++) begin
            dc_x1[ch] <= '0;
            dc_y1[ch] <= '0;
            dc_x2[ch] <= '0;
            dc_y2[ch] <= '0;
            bf_y[ch] <= '0;
            cf_y[ch] <= '0;
            for (int i = 0; i < 8; i++) begin
               hist[ch][i] <= '0;
            end
         end
      end else if (take) begin
         for (int ch = 0; ch < 2; ch++) begin
            dc_x1[ch] <= x[ch];
            dc_y1[ch] <= s1[ch];
            dc_x2[ch] <= s1[ch];
            dc_y2[ch] <= s2[ch];
            bf_y[ch] <= bf_lp[ch];
            cf_y[ch] <= cf_lp[ch];
            hist[ch][0] <= cf_out[ch];
            for (int i = 1; i < 8; i++) begin
               hist[ch][i] <= hist[ch][i-1];
            end
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         OUT_VALID <= 1'b0;
         OUT_LEFT <= '0;
         OUT_RIGHT <= '0;
      end else if (take) begin
         OUT_VALID <= 1'b1;
         OUT_LEFT <= sat(next_out[0]);
         OUT_RIGHT <= sat(next_out[1]);
      end else if (OUT_READY) begin
         OUT_VALID <= 1'b0;
      end
   end

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   sequence s_take_pass;
      take && dc_block_disable && !band_filter_enable && !widen_enable && !record_mono_mix;
   endsequence

   a_dc_reset_on: assert property ($fell(RST) |-> !dc_block_disable && !dc_block_order_select)
      else $error("dc block not enabled after reset");
   a_order_write: assert property (WRITE_STROBE && hit(`AREC_OFS_CONV_CTRL_B) |=>
      dc_block_order_select == $past(WRITE_DATA[`AREC_BIT_DC_ORDER]))
      else $error("order select did not follow write");
   a_hifi_coef: assert property (!dc_block_order_select |-> dc_coef == 12'h002)
      else $error("hi-fi coefficient wrong");
   a_band_readonly: assert property (WRITE_STROBE && hit(`AREC_OFS_CONV_CTRL_B) ##2 READ_STROBE
      && hit(`AREC_OFS_CONV_CTRL_B) |=> READ_DATA[13:12] == $past(RATE_BAND, 2))
      else $error("rate band took a write");
   a_band_off_reset: assert property ($fell(RST) |-> !band_filter_enable)
      else $error("band filter enabled after reset");
   a_coeff_read: assert property (WRITE_STROBE && hit(`AREC_OFS_BAND_COEFF) ##2 READ_STROBE
      && hit(`AREC_OFS_BAND_COEFF) |=> READ_DATA == $past(WRITE_DATA, 3))
      else $error("band coefficient readback wrong");
   a_take_output: assert property (take |=> OUT_VALID)
      else $error("pair taken without output");
   a_bypass_pass: assert property (s_take_pass |=>
      OUT_LEFT == $past(head_data[2*DATA_W-1:DATA_W]))
      else $error("bypass changed the sample");
   a_widen_mute: assert property (take && widen_enable && fwd_gain[0] == 5'h00
      && cross_gain[0] == 5'h00 |=> OUT_LEFT == '0)
      else $error("muted gains did not mute");
endmodule : arec_chain

/* verification/arec_stream_peer.sv */
/* upstream sample source and downstream sink for the chain.
   assumes one clock; the bench calls send/idle and drives stall and slow. */
module arec_stream_peer (
   input wire logic clk,
   output logic sample_valid,
   input wire logic sample_ready,
   output logic signed [23:0] sample_left,
   output logic signed [23:0] sample_right,
   input wire logic out_valid,
   output logic out_ready,
   input wire logic signed [23:0] out_left,
   input wire logic signed [23:0] out_right,
   input wire logic stall,
   input wire logic slow,
   output logic got_valid,
   output logic signed [23:0] got_left,
   output logic signed [23:0] got_right
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      sample_valid = 1'b0;
      sample_left = '0;
      sample_right = '0;
      out_ready = 1'b0;
      got_valid = 1'b0;
      got_left = '0;
      got_right = '0;
   end
   task automatic send(input logic signed [23:0] l, r, input int limit, output bit ok);
      int n;
      ok = 0;
      n = 0;
      sample_valid <= 1'b1;
      sample_left <= l;
      sample_right <= r;
      while (!ok && n < limit) begin
         @(posedge clk);
         ok = sample_ready;
         n++;
      end
   endtask : send
   // released lines show inverted data
   task automatic idle;
      sample_valid <= 1'b0;
      sample_left <= ~sample_left;
      sample_right <= ~sample_right;
   endtask : idle
   always @(posedge clk) begin
      out_ready <= !stall && (!slow || $urandom_range(1, 0) == 1);
      got_valid <= out_valid && out_ready;
      got_left <= out_left;
      got_right <= out_right;
   end
endmodule : arec_stream_peer

/* verification/tb_arec_chain.sv */
/* self-checking bench of the record-path chain against a queue model.
   assumes the stream peer as source and sink of samples. */
module tb_arec_chain;
   timeunit 1ns;
   timeprecision 100ps;
   logic CLK, RST, WRITE_STROBE, READ_STROBE, SAMPLE_VALID, SAMPLE_READY;
   logic OUT_VALID, OUT_READY, stall, slow, got_valid;
   logic [15:0] ADDRESS, WRITE_DATA, READ_DATA, v;
   logic [1:0] RATE_BAND;
   logic signed [23:0] SAMPLE_LEFT, SAMPLE_RIGHT, OUT_LEFT, OUT_RIGHT, got_left, got_right;
   logic signed [23:0] el[$], er[$];
   logic [15:0] addrs[8] = '{16'h0005, 16'h0006, 16'h0108, 16'h0109, 16'h010C, 16'h010D,
      16'h010F, 16'h0200};
   int err_count, comparisons, n, d, wen, fl, cl, dl, pl, fr, cr, dr, pr, mn, be, bt, cz, kb;
   longint hl[$], hr[$], bl, br;
   bit ok;
   arec_chain #(.DATA_W(24), .FIFO_DEPTH(8)) arec_chain_i (.CLK(CLK), .RST(RST),
      .ADDRESS(ADDRESS), .WRITE_DATA(WRITE_DATA), .WRITE_STROBE(WRITE_STROBE),
      .READ_STROBE(READ_STROBE), .READ_DATA(READ_DATA), .RATE_BAND(RATE_BAND),
      .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_READY(SAMPLE_READY), .SAMPLE_LEFT(SAMPLE_LEFT),
      .SAMPLE_RIGHT(SAMPLE_RIGHT), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY),
      .OUT_LEFT(OUT_LEFT), .OUT_RIGHT(OUT_RIGHT));
   arec_stream_peer arec_stream_peer_i (.clk(CLK), .sample_valid(SAMPLE_VALID),
      .sample_ready(SAMPLE_READY), .sample_left(SAMPLE_LEFT), .sample_right(SAMPLE_RIGHT),
      .out_valid(OUT_VALID), .out_ready(OUT_READY), .out_left(OUT_LEFT),
      .out_right(OUT_RIGHT), .stall(stall), .slow(slow), .got_valid(got_valid),
      .got_left(got_left), .got_right(got_right));
   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end
   task automatic close_out;
      if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : close_out
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [15:0] a, input logic [15:0] w);
      @(posedge CLK);
      ADDRESS <= a;
      WRITE_DATA <= w;
      WRITE_STROBE <= 1'b1;
      @(posedge CLK);
      WRITE_STROBE <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [15:0] r);
      @(posedge CLK);
      ADDRESS <= a;
      READ_STROBE <= 1'b1;
      @(posedge CLK);
      READ_STROBE <= 1'b0;
      #1 r = READ_DATA;
   endtask : rd
   function automatic longint dly(longint q[$], int k);
      return (q.size() > k) ? q[q.size() - 1 - k] : 0;
   endfunction : dly
   function automatic logic signed [23:0] side(longint own, longint oth, int f, int c, int p);
      longint s;
      s = (f == 31 ? own : 0) + (p ? -1 : 1) * (c == 31 ? oth : 0);
      if (s > 8388607) s = 8388607;
      if (s < -8388608) s = -8388608;
      return s[23:0];
   endfunction : side
   task automatic push(input int lim);
      logic signed [23:0] l, r;
      longint al, ar, ol, orr;
      l = 24'($urandom());
      r = 24'($urandom());
      arec_stream_peer_i.send(l, r, lim, ok);
      if (ok) begin
         al = bl + (((l - bl) * kb) >>> 16);
         ar = br + (((r - br) * kb) >>> 16);
         ol = be ? (bt ? l - al : al) : l;
         orr = be ? (bt ? r - ar : ar) : r;
         bl = al;
         br = ar;
         hl.push_back(cz ? 0 : ol);
         hr.push_back(cz ? 0 : orr);
         el.push_back(wen ? side(ol, dly(hr, dl), fl, cl, pl) : side(mn ? (ol + orr) >>> 1 : ol, 0, 31, 0, 0));
         er.push_back(wen ? side(orr, dly(hl, dr), fr, cr, pr) : side(mn ? (ol + orr) >>> 1 : orr, 0, 31, 0, 0));
      end else if (lim > 1) begin
         err_count++;
         close_out();
      end
   endtask : push
   task automatic drain;
      int k;
      k = 0;
      while (el.size() > 0 && k < 2000) begin
         @(posedge CLK);
         k++;
      end
      if (el.size() > 0) begin
         err_count++;
         close_out();
      end
   endtask : drain
   task automatic burst;
      repeat (10) push(200);
      arec_stream_peer_i.idle();
      drain();
   endtask : burst
   always @(posedge CLK) begin
      if (got_valid === 1'b1) begin
         if (el.size() == 0) check(48'h1, 48'h0);
         else check({got_left, got_right}, {el.pop_front(), er.pop_front()});
      end
   end
   initial begin
      void'($urandom(32'hAEE6));
      {RST, WRITE_STROBE, READ_STROBE, slow} = 4'h8;
      {ADDRESS, WRITE_DATA} = '0;
      RATE_BAND = 2'h2;
      stall = 1'b1;
      {err_count, comparisons, wen, mn, be, bt, cz, bl, br} = '0;
      repeat (8) @(posedge CLK);
      RST <= 1'b0;
      foreach (addrs[i]) begin
         rd(addrs[i], v);
         check(v, (i == 1) ? 16'h2000 : 16'h0000);
      end
      for (d = 0; d < 4; d++) begin
         RATE_BAND <= d[1:0];
         rd(16'h0006, v);
         rd(16'h0006, v);
         check(v, {2'h0, d[1:0], 12'h000});
      end
      wr(16'h0006, 16'hFFFF);
      rd(16'h0006, v);
      check(v, 16'h3780);
      wr(16'h0006, 16'h0680);
      rd(16'h0006, v);
      check(v, 16'h3680);
      n = $urandom();
      kb = n[15:0];
      wr(16'h0109, n[15:0]);
      rd(16'h0109, v);
      check(v, n[15:0]);
      wr(16'h0108, 16'h0003);
      rd(16'h0108, v);
      check(v, 16'h0003);
      wr(16'h0108, 16'h0000);
      wr(16'h0200, 16'hFFFF);
      rd(16'h0200, v);
      check(v, 16'h0000);
      wr(16'h0005, 16'h0001);
      stall <= 1'b0;
      burst();
      stall <= 1'b1;
      for (n = 0; n < 16; n++) begin
         push(1);
         if (!ok) break;
      end
      arec_stream_peer_i.idle();
      check(48'(n), 48'h9);
      stall <= 1'b0;
      slow <= 1'b1;
      drain();
      for (d = 1; d < 4; d += 2) begin
         wr(16'h0108, 16'(d));
         be = 1;
         bt = d / 2;
         burst();
      end
      wr(16'h0108, 16'h0000);
      be = 0;
      wr(16'h010A, 16'h0001);
      mn = 1;
      burst();
      for (d = 0; d <= 8; d++) begin
         fl = (d % 3 == 2) ? 0 : 31;
         cl = fl;
         cr = (d % 3 == 1) ? 0 : 31;
         fr = 31;
         pl = d % 2;
         pr = 1 - pl;
         dl = d;
         dr = 8 - d;
         cz = d[2] && !d[0];
         wen = 1;
         wr(16'h010D, {fl[4:0], cl[4:0], dl[3:0], 2'h0});
         wr(16'h010F, {fr[4:0], cr[4:0], dr[3:0], 2'h0});
         wr(16'h010C, {10'h000, pl[0], pr[0], 1'b0, d[0], d[2], 1'b1});
         rd(16'h010D, v);
         check(v, {fl[4:0], cl[4:0], dl[3:0], 2'h0});
         burst();
      end
      close_out();
   end
endmodule : tb_arec_chain
